// >>> inc/timer16_oc_map.svh
// Constants of the 16-bit timer output compare block.
// Assumes inclusion by bare name from the inc/ folder.
`ifndef TIMER16_OC_MAP_SVH
`define TIMER16_OC_MAP_SVH

`define WGM_NORMAL      4'h0
`define WGM_CTC_OCR     4'h4
`define WGM_CTC_ICR     4'hc
`define WGM_PWM_PC_OCR  4'hb
`define WGM_PWM_PFC_OCR 4'h9
`define WGM_FAST_OCR    4'hf
`define ACT_NONE        2'h0
`define ACT_TOGGLE      2'h1
`define ACT_CLEAR       2'h2
`define ACT_SET         2'h3
`define COMPARE_RESET   16'h0000
`define OUT_STATE_RESET 1'b0

`endif

// >>> inc/timer16_oc_pkg.sv
// Types shared by the output compare block.
// Assumes timer16_oc_map.svh supplies the numeric constants.
package timer16_oc_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0]  byte_t;
    typedef logic [3:0]  wave_mode_t;
    typedef logic [1:0]  action_t;
endpackage : timer16_oc_pkg

// >>> inc/oc_channel_if.sv
// Interface joining the top module to each compare channel.
// Assumes one clock domain; the top drives the shared timing signals.
`timescale 1ns/1ps
`default_nettype none
interface oc_channel_if;
    import timer16_oc_pkg::*;
    logic    wr_low;
    byte_t   wr_byte;
    byte_t   high_latch;
    action_t action;
    logic    irq_enable;
    logic    flag_clear;
    logic    irq_ack;
    logic    force_strobe;
    word_t   compare_value;
    word_t   active_value;
    logic    match;
    logic    compare_match_flag;
    logic    compare_output_state;
    logic    irq;
    modport top (output wr_low, wr_byte, high_latch, action, irq_enable, flag_clear, irq_ack,
                 force_strobe, input compare_value, active_value, match, compare_match_flag,
                 compare_output_state, irq);
    modport chan (input wr_low, wr_byte, high_latch, action, irq_enable, flag_clear, irq_ack,
                  force_strobe, output compare_value, active_value, match, compare_match_flag,
                  compare_output_state, irq);
endinterface : oc_channel_if
`default_nettype wire

// >>> hdl/oc_channel.sv
// One output compare channel: compare register, buffer, flag and output state.
// Assumes the top supplies reset copy, timer tick, TOP/BOTTOM and mode decode.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_oc_map.svh"
module oc_channel
    import timer16_oc_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  timer_tick,
    input  wire word_t timer_count,
    input  wire logic  pwm_mode,
    input  wire logic  update_point,
    input  wire logic  match_block,
    input  wire logic  wave_set,
    input  wire logic  wave_clear,
    oc_channel_if.chan ch
);
    word_t buffer_reg;
    word_t active_reg;
    logic  flag_reg;
    logic  state_reg;
    logic  flag_next;
    logic  state_next;

    wire word_t written_word = {ch.high_latch, ch.wr_byte};
    wire logic  raw_match    = (timer_count == active_reg);
    wire logic  tick_match   = timer_tick & raw_match & ~match_block;
    wire logic  forced       = ch.force_strobe & ~pwm_mode;
    wire logic  act_event    = (tick_match & ~pwm_mode) | forced;

    // ***************************************************************
    // Compare registers
    // ***************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buffer_reg <= `COMPARE_RESET;
            active_reg <= `COMPARE_RESET;
        end else begin
            // The buffer follows direct writes too, so a later switch to a PWM mode
            // cannot reload a stale value at the first update point.
            if (ch.wr_low) begin
                buffer_reg <= written_word;
            end
            if (ch.wr_low && !pwm_mode) begin
                active_reg <= written_word;
            end else if (pwm_mode && update_point && timer_tick) begin
                active_reg <= buffer_reg;
            end
        end
    end

    // ***************************************************************
    // Match flag and output state
    // ***************************************************************
    always_comb begin
        // A new match beats a clear in the same cycle so no event is lost.
        flag_next = flag_reg;
        if (ch.flag_clear || ch.irq_ack) begin
            flag_next = 1'b0;
        end
        if (tick_match) begin
            flag_next = 1'b1;
        end
        state_next = state_reg;
        if (act_event) begin
            case (ch.action)
                `ACT_TOGGLE: state_next = ~state_reg;
                `ACT_CLEAR:  state_next = 1'b0;
                `ACT_SET:    state_next = 1'b1;
                default:     state_next = state_reg;
            endcase
        end else if (pwm_mode && ch.action != `ACT_NONE) begin
            if (wave_clear) begin
                state_next = 1'b0;
            end else if (wave_set) begin
                state_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg  <= 1'b0;
            state_reg <= `OUT_STATE_RESET;
        end else begin
            flag_reg  <= flag_next;
            state_reg <= state_next;
        end
    end

    assign ch.compare_value        = pwm_mode ? buffer_reg : active_reg;
    assign ch.active_value         = active_reg;
    assign ch.match                = tick_match;
    assign ch.compare_match_flag   = flag_reg;
    assign ch.compare_output_state = state_reg;
    assign ch.irq                  = flag_reg & ch.irq_enable;
endmodule : oc_channel
`default_nettype wire

// >>> hdl/timer16_output_compare.sv
// Output compare channels A and B of a 16-bit timer with pin override.
// Assumes the counter, prescaler and capture live outside; timer_tick marks timer clock.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_oc_map.svh"
module timer16_output_compare
    import timer16_oc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       timer_tick,
    input  wire word_t      timer_count,
    input  wire logic       timer_count_write,
    input  wire logic       counter_at_top,
    input  wire logic       counter_at_bottom,
    input  wire logic       counting_down,
    input  wire wave_mode_t waveform_mode_select,
    input  wire logic       high_write,
    input  wire byte_t      wr_data,
    input  wire logic       compare_value_low_write_a,
    input  wire logic       compare_value_low_write_b,
    input  wire action_t    compare_output_action_a,
    input  wire action_t    compare_output_action_b,
    input  wire logic       compare_irq_enable_a,
    input  wire logic       compare_irq_enable_b,
    input  wire logic       flag_clear_a,
    input  wire logic       flag_clear_b,
    input  wire logic       irq_ack_a,
    input  wire logic       irq_ack_b,
    input  wire logic       force_compare_strobe_a,
    input  wire logic       force_compare_strobe_b,
    input  wire logic       port_value_a,
    input  wire logic       port_value_b,
    input  wire logic       output_pin_direction_bit_a,
    input  wire logic       output_pin_direction_bit_b,
    output logic            top_from_compare_a,
    output word_t           compare_top_value,
    output word_t           compare_value_a,
    output word_t           compare_value_b,
    output byte_t           compare_value_high_a,
    output byte_t           compare_value_high_b,
    output logic            compare_match_a,
    output logic            compare_match_b,
    output logic            compare_match_flag_a,
    output logic            compare_match_flag_b,
    output logic            compare_irq_a,
    output logic            compare_irq_b,
    output logic            compare_output_state_a,
    output logic            compare_output_state_b,
    output logic            pin_out_a,
    output logic            pin_out_b,
    output logic            pin_oe_a,
    output logic            pin_oe_b
);
    // ***************************************************************
    // Reset release and shared high-byte latch
    // ***************************************************************
    logic  rst_meta_reg;
    logic  rst_sync_reg;
    byte_t high_latch_reg;
    logic  block_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            high_latch_reg <= 8'h00;
        end else if (high_write) begin
            high_latch_reg <= wr_data;
        end
    end

    // A count write arms the block until the next timer tick consumes it,
    // so it also holds while the timer clock is stopped.
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            block_reg <= 1'b0;
        end else if (timer_count_write) begin
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            block_reg <= 1'b0;
        end
    end

    // ***************************************************************
    // Mode decode
    // ***************************************************************
    wire logic non_pwm = (waveform_mode_select == `WGM_NORMAL) ||
                         (waveform_mode_select == `WGM_CTC_OCR) ||
                         (waveform_mode_select == `WGM_CTC_ICR);
    wire logic pwm_mode = ~non_pwm;
    wire logic dual_slope = pwm_mode && (waveform_mode_select[3:2] == 2'b10 || waveform_mode_select[3:2] == 2'b00);
    wire logic pfc_mode = (waveform_mode_select[3:1] == 3'b100);
    // Fast and phase correct modes reload at TOP, phase and frequency correct at BOTTOM.
    wire logic update_point = pfc_mode ? counter_at_bottom : counter_at_top;
    // Single slope: set at BOTTOM (wrap from TOP), dual slope: restored on the way down.
    wire logic base_set  = dual_slope ? (counting_down && counter_at_top) : counter_at_top;
    wire logic match_blk = block_reg & timer_tick;
    wire logic top_a     = (waveform_mode_select == `WGM_CTC_OCR) ||
                           (waveform_mode_select == `WGM_FAST_OCR) ||
                           (waveform_mode_select == `WGM_PWM_PC_OCR) ||
                           (waveform_mode_select == `WGM_PWM_PFC_OCR);

    // ***************************************************************
    // Channels
    // ***************************************************************
    oc_channel_if ch_a ();
    oc_channel_if ch_b ();

    assign ch_a.wr_low       = compare_value_low_write_a;
    assign ch_a.wr_byte      = wr_data;
    assign ch_a.high_latch   = high_latch_reg;
    // The action fields reach only the channels and the pin override, never capture.
    assign ch_a.action       = compare_output_action_a;
    assign ch_a.irq_enable   = compare_irq_enable_a;
    assign ch_a.flag_clear   = flag_clear_a;
    assign ch_a.irq_ack      = irq_ack_a;
    assign ch_a.force_strobe = force_compare_strobe_a;
    assign ch_b.wr_low       = compare_value_low_write_b;
    assign ch_b.wr_byte      = wr_data;
    assign ch_b.high_latch   = high_latch_reg;
    assign ch_b.action       = compare_output_action_b;
    assign ch_b.irq_enable   = compare_irq_enable_b;
    assign ch_b.flag_clear   = flag_clear_b;
    assign ch_b.irq_ack      = irq_ack_b;
    assign ch_b.force_strobe = force_compare_strobe_b;

    // Inverting action (set) swaps the roles of match and base point.
    // The waveform follows the active register, not the buffer that the CPU sees.
    wire logic match_raw_a = ch_a.match;
    wire logic match_raw_b = ch_b.match;
    wire logic inv_a = (compare_output_action_a == `ACT_SET);
    wire logic inv_b = (compare_output_action_b == `ACT_SET);

    oc_channel u_chan_a (
        .clk          (clk),
        .rst_n        (rst_sync_reg),
        .timer_tick   (timer_tick),
        .timer_count  (timer_count),
        .pwm_mode     (pwm_mode),
        .update_point (update_point),
        .match_block  (match_blk),
        .wave_set     (inv_a ? match_raw_a : (base_set && timer_tick)),
        .wave_clear   (inv_a ? (base_set && timer_tick) : match_raw_a),
        .ch           (ch_a.chan)
    );

    oc_channel u_chan_b (
        .clk          (clk),
        .rst_n        (rst_sync_reg),
        .timer_tick   (timer_tick),
        .timer_count  (timer_count),
        .pwm_mode     (pwm_mode),
        .update_point (update_point),
        .match_block  (match_blk),
        .wave_set     (inv_b ? match_raw_b : (base_set && timer_tick)),
        .wave_clear   (inv_b ? (base_set && timer_tick) : match_raw_b),
        .ch           (ch_b.chan)
    );

    // ***************************************************************
    // Outputs and pin override
    // ***************************************************************
    assign top_from_compare_a     = top_a;
    assign compare_top_value      = ch_a.active_value;
    assign compare_value_a        = ch_a.compare_value;
    assign compare_value_b        = ch_b.compare_value;
    assign compare_value_high_a   = ch_a.compare_value[15:8];
    assign compare_value_high_b   = ch_b.compare_value[15:8];
    assign compare_match_a        = ch_a.match;
    assign compare_match_b        = ch_b.match;
    assign compare_match_flag_a   = ch_a.compare_match_flag;
    assign compare_match_flag_b   = ch_b.compare_match_flag;
    assign compare_irq_a          = ch_a.irq;
    assign compare_irq_b          = ch_b.irq;
    assign compare_output_state_a = ch_a.compare_output_state;
    assign compare_output_state_b = ch_b.compare_output_state;
    assign pin_out_a = (|compare_output_action_a) ? ch_a.compare_output_state : port_value_a;
    assign pin_out_b = (|compare_output_action_b) ? ch_b.compare_output_state : port_value_b;
    assign pin_oe_a  = output_pin_direction_bit_a;
    assign pin_oe_b  = output_pin_direction_bit_b;
endmodule : timer16_output_compare
`default_nettype wire

// >>> verification/timer16_oc_checker.sv
// Concurrent checks on channel A of the output compare block and on match blocking.
// Assumes binding to timer16_output_compare; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_oc_map.svh"
module timer16_oc_checker
    import timer16_oc_pkg::*;
(
    input wire logic       clk, rst_n, timer_tick, timer_count_write, compare_value_low_write_a,
    input wire wave_mode_t waveform_mode_select,
    input wire action_t    compare_output_action_a,
    input wire logic       compare_irq_enable_a, flag_clear_a, irq_ack_a, force_compare_strobe_a,
    input wire logic       port_value_a, output_pin_direction_bit_a, top_from_compare_a,
    input wire word_t      compare_value_a,
    input wire byte_t      compare_value_high_a,
    input wire logic       compare_match_a, compare_match_b, compare_match_flag_a, compare_irq_a,
    input wire logic       compare_output_state_a, pin_out_a, pin_oe_a
);
    // ****************************************
    // Helper logic and properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic blocked_reg;
    wire  non_pwm = waveform_mode_select inside {`WGM_NORMAL, `WGM_CTC_OCR, `WGM_CTC_ICR};
    wire  hit_a   = compare_match_a || force_compare_strobe_a;
    // A count write stays armed while the timer is stopped, so the block waits for a tick.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) blocked_reg <= 1'b0;
        else if (timer_count_write) blocked_reg <= 1'b1;
        else if (timer_tick) blocked_reg <= 1'b0;
    end
    property p_flag_set; compare_match_a |=> compare_match_flag_a; endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set after match");
    property p_irq; compare_irq_a == (compare_match_flag_a && compare_irq_enable_a); endproperty
    a_irq: assert property (p_irq) else $error("irq differs from flag and enable");
    property p_flag_clr; (flag_clear_a || irq_ack_a) && !compare_match_a |=> !compare_match_flag_a; endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
    property p_block; blocked_reg && timer_tick |-> !compare_match_a && !compare_match_b; endproperty
    a_block: assert property (p_block) else $error("match after count write");
    property p_force; force_compare_strobe_a && !compare_match_a && !flag_clear_a && !irq_ack_a
        |=> $stable(compare_match_flag_a); endproperty
    a_force: assert property (p_force) else $error("force changed the flag");
    property p_set; non_pwm && compare_output_action_a == `ACT_SET && hit_a |=> compare_output_state_a; endproperty
    a_set: assert property (p_set) else $error("set action did not set state");
    property p_toggle; non_pwm && compare_output_action_a == `ACT_TOGGLE && hit_a
        |=> compare_output_state_a != $past(compare_output_state_a); endproperty
    a_toggle: assert property (p_toggle) else $error("toggle action did not toggle");
    property p_hold; compare_output_action_a == `ACT_NONE |=> $stable(compare_output_state_a); endproperty
    a_hold: assert property (p_hold) else $error("state moved with no action");
    property p_pin; pin_oe_a == output_pin_direction_bit_a && pin_out_a ==
        (compare_output_action_a != `ACT_NONE ? compare_output_state_a : port_value_a); endproperty
    a_pin: assert property (p_pin) else $error("pin override wrong");
    property p_high; compare_value_high_a == compare_value_a[15:8]; endproperty
    a_high: assert property (p_high) else $error("high byte read wrong");
    property p_steady; (!compare_value_low_write_a && non_pwm) ##1 non_pwm |-> $stable(compare_value_a); endproperty
    a_steady: assert property (p_steady) else $error("compare value changed without write");
    property p_top; top_from_compare_a == (waveform_mode_select inside {4'h4, 4'h9, 4'hb, 4'hf}); endproperty
    a_top: assert property (p_top) else $error("top source wrong");
    property p_reset; $rose(rst_n) |-> !compare_output_state_a && !compare_match_flag_a; endproperty
    a_reset: assert property (p_reset) else $error("state not cleared by reset");
    c_match: cover property (compare_match_a);
    c_force: cover property (force_compare_strobe_a && non_pwm);
    c_block: cover property (blocked_reg && timer_tick);
endmodule : timer16_oc_checker
bind timer16_output_compare timer16_oc_checker i_chk (
    .clk(clk), .rst_n(rst_n), .timer_tick(timer_tick), .timer_count_write(timer_count_write),
    .compare_value_low_write_a(compare_value_low_write_a), .waveform_mode_select(waveform_mode_select),
    .compare_output_action_a(compare_output_action_a), .compare_irq_enable_a(compare_irq_enable_a),
    .flag_clear_a(flag_clear_a), .irq_ack_a(irq_ack_a), .force_compare_strobe_a(force_compare_strobe_a),
    .port_value_a(port_value_a), .output_pin_direction_bit_a(output_pin_direction_bit_a),
    .top_from_compare_a(top_from_compare_a), .compare_value_a(compare_value_a),
    .compare_value_high_a(compare_value_high_a), .compare_match_a(compare_match_a),
    .compare_match_b(compare_match_b), .compare_match_flag_a(compare_match_flag_a),
    .compare_irq_a(compare_irq_a), .compare_output_state_a(compare_output_state_a),
    .pin_out_a(pin_out_a), .pin_oe_a(pin_oe_a)
);
`default_nettype wire

// >>> verification/cpu_io_model.sv
// CPU side of the 8-bit I/O bus: compare value writes and count writes.
// Assumes the bench calls its tasks by hierarchical name; drives on falling edges.
`timescale 1ns/1ps
`default_nettype none
module cpu_io_model
    import timer16_oc_pkg::*;
(
    input  wire logic clk,
    output byte_t     wr_data,
    output logic      high_write, low_write_a, low_write_b, timer_count_write
);
    initial begin
        wr_data = 8'h00;
        {high_write, low_write_a, low_write_b, timer_count_write} = 4'h0;
    end
    // High byte first, so the shared latch is loaded before the low byte lands.
    task automatic write_compare(input logic ch, input word_t value, input int gap);
        @(negedge clk);
        high_write = 1'b1;
        wr_data = value[15:8];
        @(negedge clk);
        high_write = 1'b0;
        repeat (gap) @(negedge clk);
        low_write_a = !ch;
        low_write_b = ch;
        wr_data = value[7:0];
        @(negedge clk);
        {low_write_a, low_write_b} = 2'h0;
        wr_data = ~value[7:0];
    endtask : write_compare
    // The bench never writes a count equal to TOP or to BOTTOM while counting down.
    task automatic write_count();
        @(negedge clk);
        timer_count_write = 1'b1;
        @(negedge clk);
        timer_count_write = 1'b0;
    endtask : write_count
endmodule : cpu_io_model
`default_nettype wire

// >>> verification/test_timer16_output_compare.sv
// Self-checking bench for the output compare block with a CPU-side model.
// Assumes the checker binds itself; inputs change on falling clock edges.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_oc_map.svh"
module test_timer16_output_compare
    import timer16_oc_pkg::*;
;
    logic       clk, rst_n, timer_tick, timer_count_write, at_top, at_bottom, high_write, low_a, low_b;
    logic       irq_en_a, irq_en_b, clr_a, clr_b, ack_a, ack_b, force_a, force_b, port_a, port_b, dir_a, dir_b;
    logic       top_a, match_a, match_b, flag_a, flag_b, irq_a, irq_b, st_a, st_b, pin_a, pin_b, oe_a, oe_b;
    word_t      timer_count, top_value, cv_a, cv_b;
    wave_mode_t mode;
    action_t    act_a, act_b;
    byte_t      wr_data, cvh_a, cvh_b;
    int         failures, cmp_count;
    action_t    acts[5] = '{`ACT_SET, `ACT_NONE, `ACT_CLEAR, `ACT_TOGGLE, `ACT_TOGGLE};
    logic       exp_st[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    cpu_io_model i_cpu (.clk(clk), .wr_data(wr_data), .high_write(high_write), .low_write_a(low_a),
                        .low_write_b(low_b), .timer_count_write(timer_count_write));
    timer16_output_compare i_dut (.clk(clk), .rst_n(rst_n), .timer_tick(timer_tick), .timer_count(timer_count),
        .timer_count_write(timer_count_write), .counter_at_top(at_top), .counter_at_bottom(at_bottom),
        .counting_down(1'b0), .waveform_mode_select(mode), .high_write(high_write), .wr_data(wr_data),
        .compare_value_low_write_a(low_a), .compare_value_low_write_b(low_b), .compare_output_action_a(act_a),
        .compare_output_action_b(act_b), .compare_irq_enable_a(irq_en_a), .compare_irq_enable_b(irq_en_b),
        .flag_clear_a(clr_a), .flag_clear_b(clr_b), .irq_ack_a(ack_a), .irq_ack_b(ack_b),
        .force_compare_strobe_a(force_a), .force_compare_strobe_b(force_b), .port_value_a(port_a),
        .port_value_b(port_b), .output_pin_direction_bit_a(dir_a), .output_pin_direction_bit_b(dir_b),
        .top_from_compare_a(top_a), .compare_top_value(top_value), .compare_value_a(cv_a), .compare_value_b(cv_b),
        .compare_value_high_a(cvh_a), .compare_value_high_b(cvh_b), .compare_match_a(match_a),
        .compare_match_b(match_b), .compare_match_flag_a(flag_a), .compare_match_flag_b(flag_b),
        .compare_irq_a(irq_a), .compare_irq_b(irq_b), .compare_output_state_a(st_a), .compare_output_state_b(st_b),
        .pin_out_a(pin_a), .pin_out_b(pin_b), .pin_oe_a(oe_a), .pin_oe_b(oe_b));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic chkb(input string name, input logic seen, input logic exp);
        chk(name, {15'h0000, seen}, {15'h0000, exp});
    endtask : chkb
    task automatic strobe(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : strobe
    // The match pulse stands only while the tick is high, so it is read inside that cycle.
    task automatic tick(input word_t count, input logic top, input logic exp_match);
        @(negedge clk);
        timer_count = count;
        at_top = top;
        timer_tick = 1'b1;
        #1 chkb("match_a", match_a, exp_match);
        @(negedge clk);
        {timer_tick, at_top} = 2'h0;
    endtask : tick
    task automatic test_done();
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // ****************************************
    // Clock, watchdog and test sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #20000;
        failures++;
        test_done();
    end
    initial begin
        {rst_n, timer_tick, at_top, at_bottom, irq_en_a, irq_en_b, clr_a, clr_b, ack_a, ack_b} = 10'h000;
        {force_a, force_b, dir_a, dir_b, port_b} = 5'h00;
        port_a = 1'b1;
        timer_count = 16'h0000;
        {mode, act_a, act_b} = 8'h00;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chkb("state_a", st_a, 1'b0);
        chkb("pin_a", pin_a, 1'b1);
        chkb("oe_a", oe_a, 1'b0);
        i_cpu.write_compare(1'b0, 16'h1234, 0);
        chk("cv_a", cv_a, 16'h1234);
        chk("cvh_a", {8'h00, cvh_a}, 16'h0012);
        i_cpu.write_compare(1'b1, 16'habcd, 3);
        chk("cv_b", cv_b, 16'habcd);
        chk("cv_a", cv_a, 16'h1234);
        foreach (acts[i]) begin
            act_a = acts[i];
            strobe(force_a);
            chkb("state_a", st_a, exp_st[i]);
        end
        chkb("flag_a", flag_a, 1'b0);
        mode = `WGM_CTC_OCR;
        irq_en_a = 1'b1;
        act_a = `ACT_SET;
        dir_a = 1'b1;
        #1 chkb("pin_a", pin_a, 1'b0);
        tick(16'h1233, 1'b0, 1'b0);
        tick(16'h1234, 1'b0, 1'b1);
        chkb("flag_a", flag_a, 1'b1);
        chkb("irq_a", irq_a, 1'b1);
        chkb("state_a", st_a, 1'b1);
        chkb("flag_b", flag_b, 1'b0);
        strobe(clr_a);
        chkb("flag_a", flag_a, 1'b0);
        irq_en_a = 1'b0;
        tick(16'h1234, 1'b0, 1'b1);
        chkb("irq_a", irq_a, 1'b0);
        strobe(ack_a);
        chkb("flag_a", flag_a, 1'b0);
        i_cpu.write_count();
        repeat (2) @(negedge clk);
        tick(16'h1234, 1'b0, 1'b0);
        chkb("flag_a", flag_a, 1'b0);
        tick(16'h1234, 1'b0, 1'b1);
        act_a = `ACT_NONE;
        mode = `WGM_FAST_OCR;
        i_cpu.write_compare(1'b0, 16'h0100, 1);
        chk("cv_a", cv_a, 16'h0100);
        chk("top", top_value, 16'h1234);
        chkb("top_a", top_a, 1'b1);
        chkb("state_a", st_a, 1'b1);
        act_a = `ACT_CLEAR;
        strobe(force_a);
        chkb("state_a", st_a, 1'b1);
        act_a = `ACT_NONE;
        tick(16'h0050, 1'b1, 1'b0);
        chk("top", top_value, 16'h0100);
        chkb("state_a", st_a, 1'b1);
        act_b = `ACT_TOGGLE;
        irq_en_b = 1'b1;
        mode = `WGM_NORMAL;
        #1 chk("cv_a", cv_a, 16'h0100);
        tick(16'habcd, 1'b0, 1'b0);
        chkb("flag_b", flag_b, 1'b1);
        chkb("irq_b", irq_b, 1'b1);
        chkb("state_b", st_b, 1'b1);
        chkb("pin_b", pin_b, 1'b1);
        chkb("state_a", st_a, 1'b1);
        test_done();
    end
endmodule : test_timer16_output_compare
`default_nettype wire
